// >>> rtl/sgdt_core.v
// segment decode, display test and led diagnostics with register access
`timescale 1ns/1ns
`include "sgdt_consts.vh"
// Behaviour
// RULE_01: decode select bit n decodes digit n
// RULE_02: feature bit picks code-B or hex font
// RULE_03: code-B shows 0-9, E, H, L, P, minus
// RULE_04: hex font shows 0-9 then A-F
// RULE_05: decoder uses low nibble only
// RULE_06: top bit drives decimal point directly
// RULE_07: undecoded byte maps straight to segments
// RULE_08: test bit 0 lights all segments
// RULE_09: test bit 1 starts short diagnostics
// RULE_10: test bit 2 starts open diagnostics
// RULE_11: both requested gives OR of faults
// RULE_12: test bit 3 reads diagnostics running
// RULE_13: test bit 4 reads last-run fault
// RULE_14: host reads fault flag before details
// RULE_15: test bit 5 reads resistor open
// RULE_16: test bit 6 reads resistor shorted
// RULE_17: tests leave other registers unchanged
// RULE_18: frame bit 14 set reads, clear writes
// RULE_19: eight readable per-digit diagnostic results
// RULE_20: code-B 10-15 are minus,E,H,L,P,blank
module sgdt_core
(
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire frame_valid,
  input wire [15:0] frame_word,
  output reg [7:0] rd_data_reg,
  output reg rd_valid_reg,
  output reg [2:0] digit_sel_reg,
  output reg [7:0] segment_reg,
  output reg diag_active_reg,
  input wire [7:0] open_diag_start_sense,
  input wire [7:0] short_diag_start_sense,
  input wire current_resistor_open_sense,
  input wire current_resistor_short_sense
);
  localparam [31:0] SCAN_CYC = `SGDT_SCAN_DWELL_CYC;
  localparam [31:0] DIAG_CYC = `SGDT_DIAG_DWELL_CYC;
  localparam [15:0] SCAN_LAST = SCAN_CYC[15:0] - 16'd1;
  localparam [15:0] DIAG_LAST = DIAG_CYC[15:0] - 16'd1;
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam SENSE_W = 18;

  reg [7:0] digit_reg [0:7];
  reg [7:0] diag_result_reg [0:7];
  reg [7:0] digit_decode_select_reg;
  reg [7:0] feature_reg;
  reg optical_check_request_reg;
  reg short_diag_start_reg;
  reg open_diag_start_reg;
  reg any_fault_flag_reg;
  reg fault_acc_reg;
  reg state_reg;
  reg [2:0] diag_idx_reg;
  reg [15:0] diag_cnt_reg;
  reg [15:0] scan_cnt_reg;
  reg [2:0] scan_idx_reg;
  reg [SENSE_W-1:0] sync1_reg;
  reg [SENSE_W-1:0] sync2_reg;
  reg [SENSE_W-1:0] sync3_reg;
  reg [SENSE_W-1:0] sense_reg;

  wire frame_read = frame_word[`SGDT_FRAME_DIR_BIT];
  wire [7:0] frame_addr = {2'b00, frame_word[`SGDT_FRAME_ADDR_MSB:`SGDT_FRAME_ADDR_LSB]};
  wire [7:0] frame_data = frame_word[7:0];
  wire wr_stb = frame_valid & ~frame_read; // RULE_18
  wire rd_stb = frame_valid & frame_read; // RULE_18
  wire [7:0] open_s = sense_reg[7:0];
  wire [7:0] short_s = sense_reg[15:8];
  wire current_resistor_open_flag = sense_reg[16];
  wire current_resistor_shorted_flag = sense_reg[17];
  wire diag_running_flag = (state_reg == ST_RUN);

  // address in range check
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // test register as seen by a read
  wire [7:0] test_view = {1'b0,
    current_resistor_shorted_flag, // RULE_16
    current_resistor_open_flag, // RULE_15
    any_fault_flag_reg, // RULE_13
    diag_running_flag, // RULE_12
    2'b00, optical_check_request_reg};

  // outside sense pins: three stages, change taken when stages two and three agree
  wire [SENSE_W-1:0] sense_pins = {current_resistor_short_sense, current_resistor_open_sense,
    short_diag_start_sense, open_diag_start_sense};
  wire [SENSE_W-1:0] agree = ~(sync2_reg ^ sync3_reg);

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= {SENSE_W{1'b0}};
      sync2_reg <= {SENSE_W{1'b0}};
      sync3_reg <= {SENSE_W{1'b0}};
      sense_reg <= {SENSE_W{1'b0}};
    end
    else if (clk_en)
    begin
      sync1_reg <= sense_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      sense_reg <= (sync3_reg & agree) | (sense_reg & ~agree);
    end
  end

  // register writes; diagnostics never touch digit or control registers
  integer i;
  integer j;
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        digit_reg[i] <= `SGDT_DIGIT_RESET;
      end
      digit_decode_select_reg <= `SGDT_DECODE_SEL_RESET;
      feature_reg <= `SGDT_FEATURE_RESET;
      optical_check_request_reg <= 1'b0;
    end
    else if (clk_en && wr_stb)
    begin
      if (in_range(frame_addr, `SGDT_ADDR_DIGIT_FIRST, `SGDT_ADDR_DIGIT_LAST))
      begin
        digit_reg[frame_addr[2:0] - 3'd1] <= frame_data;
      end
      else if (frame_addr == `SGDT_ADDR_DECODE_SEL)
      begin
        digit_decode_select_reg <= frame_data;
      end
      else if (frame_addr == `SGDT_ADDR_FEATURE)
      begin
        feature_reg <= frame_data;
      end
      else if (frame_addr == `SGDT_ADDR_TEST_CTRL)
      begin
        optical_check_request_reg <= frame_data[`SGDT_TEST_OPTICAL_BIT]; // RULE_08 RULE_17
      end
    end
  end

  // register reads, answered one cycle after the frame
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid_reg <= rd_stb;
      if (rd_stb)
      begin
        if (in_range(frame_addr, `SGDT_ADDR_DIGIT_FIRST, `SGDT_ADDR_DIGIT_LAST))
        begin
          rd_data_reg <= digit_reg[frame_addr[2:0] - 3'd1];
        end
        else if (frame_addr == `SGDT_ADDR_DECODE_SEL)
        begin
          rd_data_reg <= digit_decode_select_reg;
        end
        else if (frame_addr == `SGDT_ADDR_FEATURE)
        begin
          rd_data_reg <= feature_reg;
        end
        else if (frame_addr == `SGDT_ADDR_TEST_CTRL)
        begin
          rd_data_reg <= test_view;
        end
        else if (in_range(frame_addr, `SGDT_ADDR_DIAG_FIRST, `SGDT_ADDR_DIAG_LAST))
        begin
          rd_data_reg <= diag_result_reg[frame_addr[2:0] - 3'd4]; // RULE_19
        end
        else
        begin
          rd_data_reg <= 8'h00;
        end
      end
    end
  end

  // diagnostic run: one dwell per digit, result sampled at dwell end
  wire test_wr = wr_stb && (frame_addr == `SGDT_ADDR_TEST_CTRL);
  wire start_req = test_wr && (frame_data[`SGDT_TEST_SHORT_BIT] || frame_data[`SGDT_TEST_OPEN_BIT]);
  wire [7:0] step_fault = (open_s & {8{open_diag_start_reg}}) |
    (short_s & {8{short_diag_start_reg}}); // RULE_11
  wire step_end = (diag_cnt_reg == DIAG_LAST);

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
      short_diag_start_reg <= 1'b0;
      open_diag_start_reg <= 1'b0;
      any_fault_flag_reg <= 1'b0;
      fault_acc_reg <= 1'b0;
      diag_idx_reg <= 3'd0;
      diag_cnt_reg <= 16'h0000;
      for (j = 0; j < 8; j = j + 1)
      begin
        diag_result_reg[j] <= 8'h00;
      end
    end
    else if (clk_en)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req)
          begin
            short_diag_start_reg <= frame_data[`SGDT_TEST_SHORT_BIT]; // RULE_09
            open_diag_start_reg <= frame_data[`SGDT_TEST_OPEN_BIT]; // RULE_10
            fault_acc_reg <= 1'b0;
            diag_idx_reg <= 3'd0;
            diag_cnt_reg <= 16'h0000;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (step_end)
          begin
            diag_cnt_reg <= 16'h0000;
            diag_result_reg[diag_idx_reg] <= step_fault; // RULE_19
            fault_acc_reg <= fault_acc_reg | (|step_fault);
            diag_idx_reg <= diag_idx_reg + 3'd1;
            if (diag_idx_reg == 3'd7)
            begin
              any_fault_flag_reg <= fault_acc_reg | (|step_fault); // RULE_13
              short_diag_start_reg <= 1'b0;
              open_diag_start_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          else
          begin
            diag_cnt_reg <= diag_cnt_reg + 16'h0001;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // display scan across all eight digits
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scan_cnt_reg <= 16'h0000;
      scan_idx_reg <= 3'd0;
    end
    else if (clk_en)
    begin
      if (scan_cnt_reg == SCAN_LAST)
      begin
        scan_cnt_reg <= 16'h0000;
        scan_idx_reg <= scan_idx_reg + 3'd1;
      end
      else
      begin
        scan_cnt_reg <= scan_cnt_reg + 16'h0001;
      end
    end
  end

  // segment pattern for the digit now driven
  wire [2:0] cur_idx = diag_running_flag ? diag_idx_reg : scan_idx_reg;
  wire [7:0] cur_byte = digit_reg[cur_idx];
  wire [6:0] font_seg;

  sgdt_font u_font
  (
    .code(cur_byte[3:0]), // RULE_05
    .hex_sel(feature_reg[`SGDT_FEAT_DECODE_SEL_BIT]), // RULE_02
    .seg7(font_seg)
  );

  reg [7:0] seg_next;
  always @*
  begin
    if (optical_check_request_reg || diag_running_flag)
    begin
      seg_next = 8'hff; // RULE_08
    end
    else if (digit_decode_select_reg[cur_idx])
    begin
      seg_next = {cur_byte[7], font_seg}; // RULE_01 RULE_06
    end
    else
    begin
      seg_next = cur_byte; // RULE_07
    end
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      digit_sel_reg <= 3'd0;
      segment_reg <= 8'h00;
      diag_active_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      digit_sel_reg <= cur_idx;
      segment_reg <= seg_next;
      diag_active_reg <= diag_running_flag;
    end
  end
endmodule

// >>> rtl/sgdt_consts.vh
// register map, field positions, reset values and timing counts
`ifndef SGDT_CONSTS_VH
`define SGDT_CONSTS_VH

`define SGDT_ADDR_NOOP 8'h00
`define SGDT_ADDR_DIGIT_FIRST 8'h01
`define SGDT_ADDR_DIGIT_LAST 8'h08
`define SGDT_ADDR_DECODE_SEL 8'h09
`define SGDT_ADDR_FEATURE 8'h0e
`define SGDT_ADDR_TEST_CTRL 8'h0f
`define SGDT_ADDR_DIAG_FIRST 8'h14
`define SGDT_ADDR_DIAG_LAST 8'h1b

`define SGDT_FRAME_DIR_BIT 14
`define SGDT_FRAME_ADDR_MSB 13
`define SGDT_FRAME_ADDR_LSB 8

`define SGDT_FEAT_DECODE_SEL_BIT 2

`define SGDT_TEST_OPTICAL_BIT 0
`define SGDT_TEST_SHORT_BIT 1
`define SGDT_TEST_OPEN_BIT 2
`define SGDT_TEST_RUNNING_BIT 3
`define SGDT_TEST_ANY_FAULT_BIT 4
`define SGDT_TEST_CURRENT_RESISTOR_OPEN_FLAG_BIT 5
`define SGDT_TEST_CURRENT_RESISTOR_SHORTED_FLAG_BIT 6

`define SGDT_DIGIT_RESET 8'h00
`define SGDT_DECODE_SEL_RESET 8'h00
`define SGDT_FEATURE_RESET 8'h00
`define SGDT_TEST_RESET 8'h00

`define SGDT_CLK_PERIOD_NS 10
`define SGDT_SCAN_DWELL_NS 2000
`define SGDT_SCAN_DWELL_CYC (`SGDT_SCAN_DWELL_NS / `SGDT_CLK_PERIOD_NS)
`define SGDT_DIAG_DWELL_NS 5000
`define SGDT_DIAG_DWELL_CYC (`SGDT_DIAG_DWELL_NS / `SGDT_CLK_PERIOD_NS)

`endif

// >>> rtl/sgdt_font.v
// seven-segment font decoder, code-B or hexadecimal
`timescale 1ns/1ns
module sgdt_font
(
  input wire [3:0] code,
  input wire hex_sel,
  output reg [6:0] seg7
);
  // seg7 order: a b c d e f g from bit 6 down to bit 0
  always @*
  begin
    case (code)
      4'h0: seg7 = 7'h7e;
      4'h1: seg7 = 7'h30;
      4'h2: seg7 = 7'h6d;
      4'h3: seg7 = 7'h79;
      4'h4: seg7 = 7'h33;
      4'h5: seg7 = 7'h5b;
      4'h6: seg7 = 7'h5f;
      4'h7: seg7 = 7'h70;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h7b; // RULE_03
      4'ha: seg7 = hex_sel ? 7'h77 : 7'h01; // RULE_04 RULE_20
      4'hb: seg7 = hex_sel ? 7'h1f : 7'h4f;
      4'hc: seg7 = hex_sel ? 7'h4e : 7'h37;
      4'hd: seg7 = hex_sel ? 7'h3d : 7'h0e;
      4'he: seg7 = hex_sel ? 7'h4f : 7'h67;
      default: seg7 = hex_sel ? 7'h47 : 7'h00;
    endcase
  end
endmodule

// >>> sim/sgdt_props.sv
// port-level assertions for the segment decode and diag_running_flag core
`timescale 1ns/1ns
module sgdt_props
(
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire frame_valid,
  input wire [15:0] frame_word,
  input wire [7:0] rd_data_reg,
  input wire rd_valid_reg,
  input wire [7:0] segment_reg,
  input wire diag_active_reg
);
  wire rq = clk_en && frame_valid;
  wire rd = rq && frame_word[14];
  wire wt = rq && !frame_word[14] && frame_word[13:8] == 6'h0f;
  wire rt = rd && frame_word[13:8] == 6'h0f;
  reg [12:0] run_cnt;
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      run_cnt <= 13'h0;
    else if (!diag_active_reg)
      run_cnt <= 13'h0;
    else if (clk_en)
      run_cnt <= run_cnt + 13'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_read_answer: assert property (rd |=> rd_valid_reg)
    else $error("read not answered");
  chk_write_quiet: assert property (rq && !frame_word[14] |=> !rd_valid_reg)
    else $error("write answered");
  chk_unmapped_zero: assert property (rd && frame_word[13:8] == 6'h0d |=> rd_data_reg == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rd_valid_reg |-> $stable(rd_data_reg))
    else $error("read data moved");
  chk_optical_on: assert property (wt && frame_word[0] |=> ##1 segment_reg == 8'hff)
    else $error("optical test not lit");
  chk_diag_start: assert property (wt && |frame_word[2:1] && !diag_active_reg |=> ##1 diag_active_reg)
    else $error("diagnostics not started");
  chk_run_length: assert property ($fell(diag_active_reg) |-> run_cnt >= 13'hf9f && run_cnt <= 13'hfa1)
    else $error("diagnostic run length wrong");
  chk_busy_reads: assert property (rt && diag_active_reg ##1 diag_active_reg |-> rd_data_reg[3])
    else $error("running flag low in run");
  chk_idle_reads: assert property (rt && !diag_active_reg ##1 !diag_active_reg |-> !rd_data_reg[3])
    else $error("running flag high when idle");
endmodule

// >>> sim/sgdt_led_model.sv
// led array model: fault sense of the digit being driven
`timescale 1ns/1ns
module sgdt_led_model
(
  input wire [2:0] digit_sel_reg,
  input wire [63:0] open_map,
  input wire [63:0] short_map,
  output wire [7:0] open_diag_start_sense,
  output wire [7:0] short_diag_start_sense
);
  assign open_diag_start_sense = open_map[{digit_sel_reg, 3'b000} +: 8];
  assign short_diag_start_sense = short_map[{digit_sel_reg, 3'b000} +: 8];
endmodule

// >>> sim/segment_decode_and_diag_running_flag_tb.sv
// self-checking bench for the segment decode and diag_running_flag core
`timescale 1ns/1ns
module segment_decode_and_diag_running_flag_tb;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg frame_valid = 1'b0;
  reg clk_en = 1'b1;
  reg [15:0] frame_word = 16'h0000;
  reg [63:0] open_map = 64'h0;
  reg [63:0] short_map = 64'h0;
  reg r_open = 1'b0;
  reg r_short = 1'b0;
  wire [7:0] rd_data_reg;
  wire rd_valid_reg;
  wire [2:0] digit_sel_reg;
  wire [7:0] segment_reg;
  wire diag_active_reg;
  wire [7:0] o_sense;
  wire [7:0] s_sense;
  integer n_fail = 0;
  integer comparisons = 0;
  integer i, k, r, m;
  reg [7:0] d;
  reg [7:0] dig [0:7];
  reg [7:0] dsel;
  reg hx;
  localparam [111:0] FB = {7'h00, 7'h67, 7'h0e, 7'h37, 7'h4f, 7'h01, 7'h7b, 7'h7f,
    7'h70, 7'h5f, 7'h5b, 7'h33, 7'h79, 7'h6d, 7'h30, 7'h7e};
  localparam [111:0] FH = {7'h47, 7'h4f, 7'h3d, 7'h4e, 7'h1f, 7'h77, FB[69:0]};
  always #5 core_clk = ~core_clk;
  sgdt_core dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .frame_valid(frame_valid),
    .frame_word(frame_word), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
    .digit_sel_reg(digit_sel_reg), .segment_reg(segment_reg), .diag_active_reg(diag_active_reg),
    .open_diag_start_sense(o_sense), .short_diag_start_sense(s_sense),
    .current_resistor_open_sense(r_open), .current_resistor_short_sense(r_short));
  sgdt_led_model led (.digit_sel_reg(digit_sel_reg), .open_map(open_map), .short_map(short_map),
    .open_diag_start_sense(o_sense), .short_diag_start_sense(s_sense));
  function [7:0] seg_exp(input [7:0] b, input dec, input h);
    seg_exp = !dec ? b : {b[7], h ? FH[b[3:0] * 7 +: 7] : FB[b[3:0] * 7 +: 7]};
  endfunction
  function [7:0] dres(input [2:0] q, input [1:0] mm);
    dres = (open_map[{q, 3'b000} +: 8] & {8{mm[1]}}) | (short_map[{q, 3'b000} +: 8] & {8{mm[0]}});
  endfunction
  task results;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task to;
  begin
    n_fail = n_fail + 1;
    results();
  end
  endtask
  task chk(input [7:0] g, input [7:0] e);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      n_fail = n_fail + 1;
    end
  end
  endtask
  task xf(input [15:0] fw);
    integer j;
  begin
    @(posedge core_clk);
    frame_valid <= 1'b1;
    frame_word <= fw;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    #1;
    for (j = 0; j < 4 && fw[14] && rd_valid_reg !== 1'b1; j = j + 1)
      @(posedge core_clk) #1;
    d = rd_data_reg;
    if (fw[14] && rd_valid_reg !== 1'b1)
      to();
  end
  endtask
  task wr(input [5:0] a, input [7:0] v);
    xf({2'b00, a, v});
  endtask
  task rdc(input [5:0] a, input [7:0] e);
  begin
    xf({2'b01, a, 8'h00});
    chk(d, e);
  end
  endtask
  initial
  begin
    r = $urandom(93);
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc(6'h0f, 8'h00);
    rdc(6'h09, 8'h00);
    rdc(6'h0d, 8'h00);
    for (r = 0; r < 5; r = r + 1)
    begin
      hx = r < 4 ? r[1] : $urandom;
      dsel = r < 4 ? 8'hff : $urandom;
      wr(6'h0e, {5'h0, hx, 2'h0});
      wr(6'h09, dsel);
      for (k = 0; k < 8; k = k + 1)
      begin
        dig[k] = {$urandom, r[0], k[2:0]};
        wr(k[5:0] + 6'h1, dig[k]);
      end
      for (k = 0; k < 8; k = k + 1)
      begin
        for (i = 0; i < 4000 && digit_sel_reg === k[2:0]; i = i + 1)
          @(posedge core_clk) #1;
        for (i = i; i < 4000 && digit_sel_reg !== k[2:0]; i = i + 1)
          @(posedge core_clk) #1;
        if (i == 4000)
          to();
        repeat (3) @(posedge core_clk);
        #1 chk(segment_reg, seg_exp(dig[k], dsel[k], hx));
      end
    end
    wr(6'h0f, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk(segment_reg, 8'hff);
    rdc(6'h0f, 8'h01);
    wr(6'h0f, 8'h00);
    for (m = 1; m < 4; m = m + 1)
    begin
      @(posedge core_clk);
      open_map <= {$urandom, $urandom};
      short_map <= m == 1 ? 64'h0 : {$urandom, $urandom};
      {r_open, r_short} <= m[1:0];
      wr(6'h0f, {5'h0, m[1:0], 1'b0});
      xf(16'h4f00);
      chk(d & 8'h08, 8'h08);
      for (i = 0; i < 5000 && diag_active_reg !== 1'b0; i = i + 1)
        @(posedge core_clk) #1;
      if (i == 5000)
        to();
      rdc(6'h0f, {1'b0, r_short, r_open, |((open_map & {64{m[1]}}) | (short_map & {64{m[0]}})), 4'h0});
      for (k = 0; k < 8; k = k + 1)
        rdc(6'h14 + k[5:0], dres(k[2:0], m[1:0]));
    end
    for (k = 0; k < 8; k = k + 1)
      rdc(k[5:0] + 6'h1, dig[k]);
    rdc(6'h09, dsel);
    // a frame offered while the clock enable is low is lost
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(6'h09, ~dsel);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rdc(6'h09, dsel);
    results();
  end
endmodule
bind sgdt_core sgdt_props chk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .frame_valid(frame_valid),
  .frame_word(frame_word), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
  .segment_reg(segment_reg), .diag_active_reg(diag_active_reg));
